// ==== common/cpu_regs_pkg.sv ====
// package: constants for the core programmer-model register set
package cpu_regs_pkg;
  localparam int WREG_COUNT = 16;
  localparam int WREG_W = 16;
  localparam int ACC_W = 40;
  localparam int PC_W = 23;
  localparam int FRAME_REG = 14;
  localparam int STACK_REG = 15;
  localparam logic [15:0] STACK_RESET = 16'h0800;
  // register-port addresses (word index)
  localparam logic [4:0] ADDR_WREG0 = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_TABLE_PAGE = 5'h11;
  localparam logic [4:0] ADDR_VIEW_PAGE = 5'h12;
  localparam logic [4:0] ADDR_LOOP_START = 5'h13;
  localparam logic [4:0] ADDR_LOOP_END = 5'h14;
  localparam logic [4:0] ADDR_LOOP_COUNT = 5'h15;
  localparam logic [4:0] ADDR_REPEAT_COUNT = 5'h16;
  localparam logic [4:0] ADDR_PC_LOW = 5'h17;
  localparam logic [4:0] ADDR_PC_HIGH = 5'h18;
  localparam logic [4:0] ADDR_ACCUMULATOR_A_LOW = 5'h19;
  localparam logic [4:0] ADDR_ACCUMULATOR_A_MID = 5'h1a;
  localparam logic [4:0] ADDR_ACCUMULATOR_A_HIGH = 5'h1b;
  localparam logic [4:0] ADDR_ACCUMULATOR_B_LOW = 5'h1c;
  localparam logic [4:0] ADDR_ACCUMULATOR_B_MID = 5'h1d;
  localparam logic [4:0] ADDR_ACCUMULATOR_B_HIGH = 5'h1e;
  // status word bit positions
  localparam int SR_CARRY = 0;
  localparam int SR_ZERO = 1;
  localparam int SR_OVERFLOW = 2;
  localparam int SR_NEGATIVE = 3;
  localparam int SR_REPEAT_ACTIVE = 4;
  localparam int SR_PRIO_LO = 5;
  localparam int SR_DIGIT_CARRY = 8;
  localparam int SR_LOOP_ACTIVE = 9;
  localparam logic [15:0] SR_SHADOW_MASK = 16'h010f;
  localparam logic [15:0] PC_LOW_MASK = 16'hfffe;
endpackage : cpu_regs_pkg

// ==== hdl/cpu_shadow_set.sv ====
// shadow holding registers for the block-pushed register groups
`timescale 1ns/1ps
`default_nettype none
module cpu_shadow_set #(
  parameter int WIDTH = 16,
  parameter int COUNT = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // capture
  input wire logic push,
  input wire logic [COUNT*WIDTH-1:0] host_value,
  // restore
  output logic [COUNT*WIDTH-1:0] shadow_value
);
  logic [COUNT*WIDTH-1:0] next_shadow_value;

  // no software path: only push loads the shadows
  always_comb begin
    next_shadow_value = shadow_value;
    if (push) begin
      next_shadow_value = host_value;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_value <= '0;
    end else begin
      shadow_value <= next_shadow_value;
    end
  end
endmodule // cpu_shadow_set
`default_nettype wire

// ==== hdl/cpu_programmer_model_regs.sv ====
// programmer-model register file of the core: working regs, accumulators, status, loop, pc
// Notes on behaviour
// RULE_01: sixteen 16-bit working registers usable as data, address or offset.
// RULE_02: two 40-bit accumulators plus page, loop, repeat and pc registers.
// RULE_03: all registers memory mapped; register 0 is the default working register.
// RULE_04: shadows have no direct access; they move only on their events.
// RULE_05: shadow push/pop moves registers 0-3 and five status flags only.
// RULE_06: loop start pushes loop start/end/count shadows; loop end pops them.
// RULE_07: byte operation on a working register changes only its low byte.
// RULE_08: byte-wide memory accesses reach either byte of any working register.
// RULE_09: stack pointer updated by exceptions, calls, returns; still ordinary register.
// RULE_10: stack pointer bit 0 always reads zero.
// RULE_11: stack pointer resets to 0x0800.
// RULE_12: frame pointer used by link/unlink, otherwise an ordinary register.
// RULE_13: status word is 16 bits, split in low and high bytes.
// RULE_14: low status byte holds alu flags, priority level and repeat active.
// RULE_15: exception entry stacks low status byte joined with pc top byte.
// RULE_16: high status byte holds dsp status, loop active and digit carry.
// RULE_17: pc is 23 bits with bit 0 always zero.
// RULE_18: other working regs, accumulators and shadows clear on reset.
`timescale 1ns/1ps
`default_nettype none
module cpu_programmer_model_regs
  import cpu_regs_pkg::*;
#(
  parameter int AW = 5
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // memory-mapped register port
  input wire logic [AW-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [1:0] BYTE_EN,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // execution unit working-register write
  input wire logic EX_WE,
  input wire logic [3:0] EX_SEL,
  input wire logic EX_BYTE,
  input wire logic [15:0] EX_DATA,
  // execution unit status, accumulator and pc updates
  input wire logic SR_WE,
  input wire logic [15:0] SR_DATA,
  input wire logic ACC_WE,
  input wire logic ACC_SEL,
  input wire logic [39:0] ACC_DATA,
  input wire logic PC_WE,
  input wire logic [22:0] PC_DATA,
  // shadow and loop events
  input wire logic SHADOW_PUSH,
  input wire logic SHADOW_POP,
  input wire logic LOOP_START,
  input wire logic LOOP_END,
  input wire logic [15:0] LOOP_START_VAL,
  input wire logic [15:0] LOOP_END_VAL,
  input wire logic [15:0] LOOP_COUNT_VAL,
  // stack events
  input wire logic SP_WE,
  input wire logic [15:0] SP_DATA,
  input wire logic EXC_ENTRY,
  // state seen by the execution unit
  output logic [15:0] STACK_PTR,
  output logic [15:0] FRAME_PTR,
  output logic [15:0] DEFAULT_WREG,
  output logic [15:0] STATUS,
  output logic [22:0] PROG_COUNTER,
  output logic [15:0] EXC_STACK_WORD,
  output logic EXC_STACK_VALID
);
  import cpu_regs_pkg::*;

  logic [15:0] wreg [WREG_COUNT];
  logic [15:0] next_wreg [WREG_COUNT];
  logic [ACC_W-1:0] acc_a, acc_b, next_acc_a, next_acc_b;
  logic [15:0] status_word, next_status_word;
  logic [15:0] table_page, view_page, next_table_page, next_view_page;
  logic [15:0] loop_start, loop_end, loop_count;
  logic [15:0] next_loop_start, next_loop_end, next_loop_count;
  logic [15:0] repeat_count, next_repeat_count;
  logic [PC_W-1:0] pc, next_pc;
  logic [15:0] rdata_q, next_rdata;
  logic [15:0] exc_word, next_exc_word;
  logic exc_valid, next_exc_valid;
  logic [79:0] wsh_host, wsh_val;
  logic [15:0] ssh_val;
  logic [47:0] lsh_host, lsh_val;

  function automatic logic [15:0] merge_bytes(input logic [15:0] old, input logic [15:0] nw,
                                              input logic [1:0] be);
    merge_bytes = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // shadows: working 0-3 plus masked status in one set, loop regs in another [RULE_04]
  assign wsh_host = {status_word & SR_SHADOW_MASK, wreg[3], wreg[2], wreg[1], wreg[0]};
  assign lsh_host = {loop_count, loop_end, loop_start};
  assign ssh_val = wsh_val[79:64];

  cpu_shadow_set #(.WIDTH(16), .COUNT(5)) u_work_shadow (
    .clk(CLK),
    .reset_n(RESET_N),
    .push(SHADOW_PUSH),
    .host_value(wsh_host),
    .shadow_value(wsh_val)
  );

  // pushed on loop start, holds the outer loop's values [RULE_06]
  cpu_shadow_set #(.WIDTH(16), .COUNT(3)) u_loop_shadow (
    .clk(CLK),
    .reset_n(RESET_N),
    .push(LOOP_START),
    .host_value(lsh_host),
    .shadow_value(lsh_val)
  );

  always_comb begin
    for (int i = 0; i < WREG_COUNT; i++) begin
      next_wreg[i] = wreg[i];
    end
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_status_word = status_word;
    next_table_page = table_page;
    next_view_page = view_page;
    next_loop_start = loop_start;
    next_loop_end = loop_end;
    next_loop_count = loop_count;
    next_repeat_count = repeat_count;
    next_pc = pc;
    // bus writes, byte lanes independent for any working register [RULE_03] [RULE_08]
    if (WR) begin
      if (ADDR < AW'(WREG_COUNT)) begin
        next_wreg[ADDR[3:0]] = merge_bytes(wreg[ADDR[3:0]], WDATA, BYTE_EN);
      end else begin
        case (ADDR)
          ADDR_STATUS: next_status_word = merge_bytes(status_word, WDATA, BYTE_EN); // [RULE_13]
          ADDR_TABLE_PAGE: next_table_page = merge_bytes(table_page, WDATA, BYTE_EN);
          ADDR_VIEW_PAGE: next_view_page = merge_bytes(view_page, WDATA, BYTE_EN);
          ADDR_LOOP_START: next_loop_start = merge_bytes(loop_start, WDATA, BYTE_EN);
          ADDR_LOOP_END: next_loop_end = merge_bytes(loop_end, WDATA, BYTE_EN);
          ADDR_LOOP_COUNT: next_loop_count = merge_bytes(loop_count, WDATA, BYTE_EN);
          ADDR_REPEAT_COUNT: next_repeat_count = merge_bytes(repeat_count, WDATA, BYTE_EN);
          ADDR_PC_LOW: next_pc[15:0] = merge_bytes(pc[15:0], WDATA, BYTE_EN);
          ADDR_PC_HIGH: if (BYTE_EN[0]) next_pc[22:16] = WDATA[6:0];
          ADDR_ACCUMULATOR_A_LOW: next_acc_a[15:0] = merge_bytes(acc_a[15:0], WDATA, BYTE_EN);
          ADDR_ACCUMULATOR_A_MID: next_acc_a[31:16] = merge_bytes(acc_a[31:16], WDATA, BYTE_EN);
          ADDR_ACCUMULATOR_A_HIGH: if (BYTE_EN[0]) next_acc_a[39:32] = WDATA[7:0];
          ADDR_ACCUMULATOR_B_LOW: next_acc_b[15:0] = merge_bytes(acc_b[15:0], WDATA, BYTE_EN);
          ADDR_ACCUMULATOR_B_MID: next_acc_b[31:16] = merge_bytes(acc_b[31:16], WDATA, BYTE_EN);
          ADDR_ACCUMULATOR_B_HIGH: if (BYTE_EN[0]) next_acc_b[39:32] = WDATA[7:0];
          default: ;
        endcase
      end
    end
    // execution results win over the bus in the same cycle
    if (EX_WE) begin
      next_wreg[EX_SEL] = EX_BYTE ? {wreg[EX_SEL][15:8], EX_DATA[7:0]} : EX_DATA; // [RULE_01] [RULE_07] [RULE_12]
    end
    if (SR_WE) begin
      next_status_word = SR_DATA; // [RULE_14] [RULE_16]
    end
    if (ACC_WE) begin
      if (ACC_SEL) next_acc_b = ACC_DATA; // [RULE_02]
      else next_acc_a = ACC_DATA;
    end
    if (PC_WE) begin
      next_pc = PC_DATA;
    end
    if (SP_WE) begin
      next_wreg[STACK_REG] = SP_DATA; // [RULE_09]
    end
    // pop restores only the masked flags, other status bits stay [RULE_05]
    if (SHADOW_POP) begin
      for (int i = 0; i < 4; i++) begin
        next_wreg[i] = wsh_val[16*i +: 16];
      end
      next_status_word = (status_word & ~SR_SHADOW_MASK) | (ssh_val & SR_SHADOW_MASK);
    end
    if (LOOP_START) begin
      next_loop_start = LOOP_START_VAL;
      next_loop_end = LOOP_END_VAL;
      next_loop_count = LOOP_COUNT_VAL;
    end else if (LOOP_END) begin
      {next_loop_count, next_loop_end, next_loop_start} = lsh_val; // [RULE_06]
    end
    next_wreg[STACK_REG][0] = 1'b0; // [RULE_10]
    next_pc[0] = 1'b0; // [RULE_17]
  end

  // read path, data one cycle after strobe; unmapped reads zero
  always_comb begin
    next_rdata = 16'h0000;
    if (RD) begin
      if (ADDR < AW'(WREG_COUNT)) begin
        next_rdata = wreg[ADDR[3:0]];
      end else begin
        case (ADDR)
          ADDR_STATUS: next_rdata = status_word;
          ADDR_TABLE_PAGE: next_rdata = table_page;
          ADDR_VIEW_PAGE: next_rdata = view_page;
          ADDR_LOOP_START: next_rdata = loop_start;
          ADDR_LOOP_END: next_rdata = loop_end;
          ADDR_LOOP_COUNT: next_rdata = loop_count;
          ADDR_REPEAT_COUNT: next_rdata = repeat_count;
          ADDR_PC_LOW: next_rdata = pc[15:0];
          ADDR_PC_HIGH: next_rdata = {9'h000, pc[22:16]};
          ADDR_ACCUMULATOR_A_LOW: next_rdata = acc_a[15:0];
          ADDR_ACCUMULATOR_A_MID: next_rdata = acc_a[31:16];
          ADDR_ACCUMULATOR_A_HIGH: next_rdata = {8'h00, acc_a[39:32]};
          ADDR_ACCUMULATOR_B_LOW: next_rdata = acc_b[15:0];
          ADDR_ACCUMULATOR_B_MID: next_rdata = acc_b[31:16];
          ADDR_ACCUMULATOR_B_HIGH: next_rdata = {8'h00, acc_b[39:32]};
          default: next_rdata = 16'h0000;
        endcase
      end
    end
  end

  // exception stack word: low status byte with top pc byte [RULE_15]
  always_comb begin
    next_exc_valid = EXC_ENTRY;
    next_exc_word = exc_word;
    if (EXC_ENTRY) begin
      next_exc_word = {status_word[7:0], 1'b0, pc[22:16]};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < WREG_COUNT; i++) begin
        wreg[i] <= (i == STACK_REG) ? STACK_RESET : 16'h0000; // [RULE_11] [RULE_18]
      end
      acc_a <= '0;
      acc_b <= '0;
      status_word <= 16'h0000;
      table_page <= 16'h0000;
      view_page <= 16'h0000;
      loop_start <= 16'h0000;
      loop_end <= 16'h0000;
      loop_count <= 16'h0000;
      repeat_count <= 16'h0000;
      pc <= '0;
      rdata_q <= 16'h0000;
      exc_word <= 16'h0000;
      exc_valid <= 1'b0;
    end else begin
      for (int i = 0; i < WREG_COUNT; i++) begin
        wreg[i] <= next_wreg[i];
      end
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      status_word <= next_status_word;
      table_page <= next_table_page;
      view_page <= next_view_page;
      loop_start <= next_loop_start;
      loop_end <= next_loop_end;
      loop_count <= next_loop_count;
      repeat_count <= next_repeat_count;
      pc <= next_pc;
      rdata_q <= next_rdata;
      exc_word <= next_exc_word;
      exc_valid <= next_exc_valid;
    end
  end

  assign RDATA = rdata_q;
  assign STACK_PTR = wreg[STACK_REG];
  assign FRAME_PTR = wreg[FRAME_REG];
  assign DEFAULT_WREG = wreg[0];
  assign STATUS = status_word;
  assign PROG_COUNTER = pc;
  assign EXC_STACK_WORD = exc_word;
  assign EXC_STACK_VALID = exc_valid;

  a_sp_aligned: assert property (@(posedge CLK) disable iff (!RESET_N) STACK_PTR[0] == 1'b0)
    else $error("stack pointer bit 0 set"); // [RULE_10]
  a_pc_aligned: assert property (@(posedge CLK) disable iff (!RESET_N) PROG_COUNTER[0] == 1'b0)
    else $error("pc bit 0 set"); // [RULE_17]
  a_byte_keep_high: assert property (@(posedge CLK) disable iff (!RESET_N)
    EX_WE && EX_BYTE && !SHADOW_POP && !SP_WE && !WR |=> wreg[$past(EX_SEL)][15:8] == $past(wreg[EX_SEL][15:8]))
    else $error("byte op changed high byte"); // [RULE_07]
  a_pop_wreg0: assert property (@(posedge CLK) disable iff (!RESET_N)
    SHADOW_PUSH ##1 (!SHADOW_PUSH && SHADOW_POP) |=> DEFAULT_WREG == $past(wreg[0], 2))
    else $error("pop did not restore reg 0"); // [RULE_05]
  a_pop_keeps_prio: assert property (@(posedge CLK) disable iff (!RESET_N)
    SHADOW_POP && !SR_WE |=> STATUS[7:4] == $past(STATUS[7:4]))
    else $error("pop touched non-shadow status bits"); // [RULE_05]
  a_loop_restore: assert property (@(posedge CLK) disable iff (!RESET_N)
    LOOP_START ##1 (LOOP_END && !LOOP_START) |=> loop_start == $past(loop_start, 2))
    else $error("loop end did not restore start"); // [RULE_06]
  a_exc_word: assert property (@(posedge CLK) disable iff (!RESET_N)
    EXC_ENTRY |=> EXC_STACK_VALID && EXC_STACK_WORD == {$past(STATUS[7:0]), 1'b0, $past(PROG_COUNTER[22:16])})
    else $error("exception stack word wrong"); // [RULE_15]
  a_read_data: assert property (@(posedge CLK) disable iff (!RESET_N)
    RD && ADDR == ADDR_STATUS |=> RDATA == $past(STATUS))
    else $error("status read mismatch"); // [RULE_13]
endmodule // cpu_programmer_model_regs
`default_nettype wire

// ==== tb/exec_unit_model.sv ====
// execution-unit model driving the core-side strobes of the register file
`timescale 1ns/1ps
`default_nettype none
module exec_unit_model (
  // clock
  input wire logic clk,
  // working-register and status writes
  output wire logic ex_we,
  output wire logic [3:0] ex_sel,
  output wire logic ex_byte,
  output wire logic [15:0] ex_data,
  output wire logic sr_we,
  output wire logic [15:0] sr_data,
  // accumulator, pc and stack updates
  output wire logic acc_we,
  output wire logic acc_sel,
  output wire logic [39:0] acc_data,
  output wire logic pc_we,
  output wire logic [22:0] pc_data,
  output wire logic sp_we,
  output wire logic [15:0] sp_data,
  output wire logic exc_entry,
  // shadow and loop events
  output wire logic shadow_push,
  output wire logic shadow_pop,
  output wire logic loop_start,
  output wire logic loop_end,
  output wire logic [15:0] loop_start_val,
  output wire logic [15:0] loop_end_val,
  output wire logic [15:0] loop_count_val
);
  logic [9:0] stb = '0;
  logic [47:0] d = '0;
  logic [3:0] s = '0;
  logic b = 1'b0;
  assign {exc_entry, sp_we, loop_end, loop_start, shadow_pop, shadow_push, pc_we, acc_we, sr_we, ex_we} = stb;
  assign ex_sel = s;
  assign acc_sel = s[0];
  assign ex_byte = b;
  assign ex_data = d[15:0];
  assign sr_data = d[15:0];
  assign sp_data = d[15:0];
  assign acc_data = d[39:0];
  assign pc_data = d[22:0];
  assign loop_start_val = d[15:0];
  assign loop_end_val = d[31:16];
  assign loop_count_val = d[47:32];
  // one strobe k for one cycle, data held until the taking edge
  task automatic run(input int k, input logic [47:0] v, input logic [3:0] sel, input logic byt);
    @(posedge clk);
    d <= v;
    s <= sel;
    b <= byt;
    stb <= 10'(1 << k);
    @(posedge clk);
    stb <= '0;
    // released data must not look stable to the design
    d <= ~v;
  endtask
  // two strobe sets on adjacent edges, for back-to-back event pairs
  task automatic run2(input logic [9:0] s1, input logic [9:0] s2, input logic [47:0] v, input logic [3:0] sel);
    @(posedge clk);
    d <= v;
    s <= sel;
    b <= 1'b0;
    stb <= s1;
    @(posedge clk);
    stb <= s2;
    @(posedge clk);
    stb <= '0;
    d <= ~v;
  endtask
endmodule // exec_unit_model
`default_nettype wire

// ==== tb/cpu_programmer_model_regs_tb_top.sv ====
// self-checking bench for the programmer-model register file
`timescale 1ns/1ps
`default_nettype none
module cpu_programmer_model_regs_tb_top;
  import cpu_regs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] addr = '0;
  logic [15:0] wdata = '0;
  logic [1:0] be = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, sp, fp, w0, status, exc_word, sr_d, ex_d, sp_d, ls_d, le_d, lc_d, v;
  logic [22:0] pc, pc_d;
  logic [39:0] acc_d;
  logic [3:0] ex_sel;
  logic ex_we, ex_byte, sr_we, acc_we, acc_sel, pc_we, push, pop, lstart, lend, sp_we, exc, exc_valid;
  logic [15:0] m [0:31];
  logic [15:0] sv [0:4];
  logic [47:0] r;
  int seed = 32'hec7f651e;
  int n_mismatch = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  cpu_programmer_model_regs cpu_programmer_model_regs_i (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
    .WDATA(wdata), .BYTE_EN(be), .WR(wr), .RD(rd), .RDATA(rdata), .EX_WE(ex_we), .EX_SEL(ex_sel),
    .EX_BYTE(ex_byte), .EX_DATA(ex_d), .SR_WE(sr_we), .SR_DATA(sr_d), .ACC_WE(acc_we), .ACC_SEL(acc_sel),
    .ACC_DATA(acc_d), .PC_WE(pc_we), .PC_DATA(pc_d), .SHADOW_PUSH(push), .SHADOW_POP(pop),
    .LOOP_START(lstart), .LOOP_END(lend), .LOOP_START_VAL(ls_d), .LOOP_END_VAL(le_d),
    .LOOP_COUNT_VAL(lc_d), .SP_WE(sp_we), .SP_DATA(sp_d), .EXC_ENTRY(exc), .STACK_PTR(sp),
    .FRAME_PTR(fp), .DEFAULT_WREG(w0), .STATUS(status), .PROG_COUNTER(pc), .EXC_STACK_WORD(exc_word),
    .EXC_STACK_VALID(exc_valid));
  exec_unit_model exec_unit_model_i (.clk(clk), .ex_we(ex_we), .ex_sel(ex_sel), .ex_byte(ex_byte),
    .ex_data(ex_d), .sr_we(sr_we), .sr_data(sr_d), .acc_we(acc_we), .acc_sel(acc_sel), .acc_data(acc_d),
    .pc_we(pc_we), .pc_data(pc_d), .sp_we(sp_we), .sp_data(sp_d), .exc_entry(exc), .shadow_push(push),
    .shadow_pop(pop), .loop_start(lstart), .loop_end(lend), .loop_start_val(ls_d), .loop_end_val(le_d),
    .loop_count_val(lc_d));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), m[a], rdata);
  endtask
  function automatic void put(input int a, input logic [15:0] d, input logic [1:0] b);
    if (b[0]) m[a][7:0] = d[7:0];
    if (b[1]) m[a][15:8] = d[15:8];
    if (a == STACK_REG) m[a][0] = 1'b0;
  endfunction
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    for (int i = 0; i < 32; i++) m[i] = '0;
    m[STACK_REG] = STACK_RESET;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 32; i++) rd_chk(5'(i));
    chk("sp", STACK_RESET, sp);
    $display("reset test done");
    for (int i = 0; i < 23; i++) begin
      v = 16'($random(seed));
      r[1:0] = 2'($random(seed));
      wr_reg(5'(i), v, r[1:0]);
      put(i, v, r[1:0]);
    end
    for (int i = 0; i < 23; i++) rd_chk(5'(i));
    chk("w0", m[0], w0);
    chk("fp", m[FRAME_REG], fp);
    $display("bus test done");
    for (int i = 0; i < 16; i++) begin
      v = 16'($random(seed));
      exec_unit_model_i.run(0, {32'h0, v}, 4'(i), i[0]);
      put(i, v, i[0] ? 2'b01 : 2'b11);
    end
    for (int i = 0; i < 16; i++) rd_chk(5'(i));
    v = 16'($random(seed)) | 16'h1;
    exec_unit_model_i.run(8, {32'h0, v}, 4'h0, 1'b0);
    #1;
    put(STACK_REG, v, 2'b11);
    chk("sp", m[STACK_REG], sp);
    $display("execution write test done");
    v = 16'($random(seed));
    exec_unit_model_i.run(1, {32'h0, v}, 4'h0, 1'b0);
    m[16] = v;
    exec_unit_model_i.run(4, '0, 4'h0, 1'b0);
    for (int i = 0; i < 5; i++) sv[i] = m[i < 4 ? i : 16];
    for (int i = 0; i < 5; i++) begin
      v = 16'($random(seed));
      exec_unit_model_i.run(i < 4 ? 0 : 1, {32'h0, v}, 4'(i), 1'b0);
      m[i < 4 ? i : 16] = v;
    end
    exec_unit_model_i.run(5, '0, 4'h0, 1'b0);
    for (int i = 0; i < 4; i++) m[i] = sv[i];
    m[16] = (m[16] & ~SR_SHADOW_MASK) | (sv[4] & SR_SHADOW_MASK);
    for (int i = 0; i < 4; i++) rd_chk(5'(i));
    chk("status", m[16], status);
    // push then pop with a competing reg 0 write: pop must win and restore
    v = 16'($random(seed));
    exec_unit_model_i.run2(10'h010, 10'h021, {32'h0, v}, 4'h0);
    for (int i = 0; i < 4; i++) rd_chk(5'(i));
    chk("status pair", m[16], status);
    $display("shadow test done");
    for (int j = 0; j < 2; j++) begin
      r = 48'({$random(seed), $random(seed)});
      exec_unit_model_i.run(6, r, 4'h0, 1'b0);
      for (int i = 0; i < 3; i++) begin
        sv[i] = m[19 + i];
        m[19 + i] = r[16 * i +: 16];
      end
    end
    for (int i = 19; i < 22; i++) rd_chk(5'(i));
    exec_unit_model_i.run(7, '0, 4'h0, 1'b0);
    for (int i = 0; i < 3; i++) m[19 + i] = sv[i];
    for (int i = 19; i < 22; i++) rd_chk(5'(i));
    // start immediately followed by end: loop regs fall back to their old values
    r = 48'({$random(seed), $random(seed)});
    exec_unit_model_i.run2(10'h040, 10'h080, r, 4'h0);
    for (int i = 19; i < 22; i++) rd_chk(5'(i));
    $display("loop test done");
    for (int j = 0; j < 2; j++) begin
      r = 48'({$random(seed), $random(seed)});
      exec_unit_model_i.run(2, r, 4'(j), 1'b0);
      m[25 + 3 * j] = r[15:0];
      m[26 + 3 * j] = r[31:16];
      m[27 + 3 * j] = {8'h0, r[39:32]};
    end
    for (int i = 25; i < 31; i++) rd_chk(5'(i));
    r = 48'({$random(seed), $random(seed)});
    exec_unit_model_i.run(3, r, 4'h0, 1'b0);
    m[23] = r[15:0] & PC_LOW_MASK;
    m[24] = {9'h0, r[22:16]};
    for (int i = 23; i < 25; i++) rd_chk(5'(i));
    chk("pc low", m[23], pc[15:0]);
    exec_unit_model_i.run(9, '0, 4'h0, 1'b0);
    #1;
    chk("exc valid", 16'h1, {15'h0, exc_valid});
    chk("exc word", {m[16][7:0], m[24][7:0]}, exc_word);
    @(posedge clk);
    #1;
    chk("exc pulse", 16'h0, {15'h0, exc_valid});
    $display("accumulator, pc and exception test done");
    print_verdict();
  end
endmodule // cpu_programmer_model_regs_tb_top
`default_nettype wire
